// ---- hw/etd_pattern_gen.sv ----
// module: pseudo-random bit source for the active loop pattern
`timescale 1ns/10ps
`default_nettype none
module etd_pattern_gen (
   input wire logic i_clk, // system clock
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_run, // advance the pattern
   output logic o_bit // current pattern bit
);
   import etd_pkg::*;
   // -----------------------------------------------------------------
   // galois lfsr
   // -----------------------------------------------------------------
   logic [15:0] lfsr_q; // shift state
   logic [15:0] lfsr_d; // next state
   // a maximal sequence keeps the pattern hard to replay with a stub
   assign lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS)
                             : (lfsr_q >> 1);
   // stepping only while armed in pattern mode keeps the output quiet otherwise
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lfsr_q <= LFSR_SEED;
      end else if (i_run) begin
         lfsr_q <= lfsr_d;
      end
   end
   assign o_bit = lfsr_q[0];
endmodule
`default_nettype wire

// ---- hw/etd_pkg.sv ----
// package: register map, field layout, states and timing of the detector
package etd_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [11:0] ETD_CTRL_OFS = 12'h000; // control
   localparam logic [11:0] ETD_STAT_OFS = 12'h004; // status, flag w1c
   localparam logic [11:0] ETD_PWR_OFS = 12'h008; // low-power request
   localparam logic [11:0] ETD_WKEN_OFS = 12'h00c; // hibernate wake en
   localparam logic [11:0] ETD_BKP_OFS = 12'h010; // retained backup regs
   localparam int ETD_BKP_NUM = 4; // backup words
   // -----------------------------------------------------------------
   // control fields
   // -----------------------------------------------------------------
   localparam int CTRL_DET_EN = 0; // loop armed, drive enabled
   localparam int CTRL_ACTIVE = 1; // 1 pattern mode, 0 static level
   localparam int CTRL_INVERT = 2; // passive idle level high
   localparam int CTRL_SBOOT = 3; // verify image on cold boot
   localparam int CTRL_INIT_DONE = 4; // tamper setup finished
   localparam int CTRL_NS_GO = 5; // launch non-secure app
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RST = 6'h00;
   // -----------------------------------------------------------------
   // status fields
   // -----------------------------------------------------------------
   localparam int STAT_FLAG = 0; // sticky tamper event
   localparam int STAT_LIVE = 1; // mismatch seen last cycle
   localparam int STAT_ST_LSB = 2; // one-hot state, 10 bits
   localparam int STAT_COLD = 12; // last wake was a cold boot
   // -----------------------------------------------------------------
   // wake enables, power modes, pattern
   // -----------------------------------------------------------------
   localparam int WK_GPIO = 0;
   localparam int WK_RTC = 1;
   localparam int WK_WDT = 2;
   localparam int WK_LPC = 3;
   localparam logic [3:0] WKEN_RST = 4'hf;
   localparam logic [1:0] PM_SLEEP = 2'h0;
   localparam logic [1:0] PM_DSLEEP = 2'h1;
   localparam logic [1:0] PM_DSOFF = 2'h2;
   localparam logic [1:0] PM_HIBER = 2'h3;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int DS_RESUME_NS = 20000; // strictly under this
   localparam logic [31:0] DS_RESUME_CYC =
      32'(DS_RESUME_NS * CLK_MHZ / 1000 - 1);
   localparam int POR_US = 540;
   localparam int unsigned ETD_POR_CYC = POR_US * CLK_MHZ;
   localparam int BOOT_MS = 25;
   localparam int unsigned ETD_BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
   // -----------------------------------------------------------------
   // power sequencer states, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [9:0] {
      ST_RUN = 10'h001,
      ST_SLEEP = 10'h002,
      ST_DSLEEP = 10'h004,
      ST_RESUME = 10'h008,
      ST_DSOFF = 10'h010,
      ST_HIBER = 10'h020,
      ST_POR = 10'h040,
      ST_BOOT = 10'h080,
      ST_VERIFY = 10'h100,
      ST_HALT = 10'h200
   } etd_state_t;
endpackage

// ---- hw/etd_top.sv ----
// module: tamper loop detector with ahb-lite registers and power sequencer
`timescale 1ns/10ps
`default_nettype none
module etd_top #(
   parameter int unsigned P_POR_CYC = etd_pkg::ETD_POR_CYC, // por wait
   parameter int unsigned P_BOOT_CYC = etd_pkg::ETD_BOOT_CYC // boot wait
) (
   input wire logic I_SYS_CLK, // system clock
   input wire logic I_RST_B, // power-on reset, active low
   input wire logic I_HSEL, // ahb select
   input wire logic [11:0] I_HADDR, // ahb address
   input wire logic [1:0] I_HTRANS, // ahb transfer type
   input wire logic I_HWRITE, // ahb write
   input wire logic [2:0] I_HSIZE, // ahb size, word only
   input wire logic [31:0] I_HWDATA, // ahb write data
   input wire logic I_HREADY, // ahb bus ready
   output logic [31:0] O_HRDATA, // ahb read data
   output logic O_HREADYOUT, // ahb slave ready
   output logic O_HRESP, // ahb response, okay
   input wire logic I_TAMPER_IN, // returned loop sense
   output logic O_TAMPER_OUT, // loop drive value
   output logic O_TAMPER_OE, // loop drive enable
   output logic O_TAMPER_EVT, // sticky tamper flag
   input wire logic I_IRQ_ANY, // any other interrupt
   input wire logic I_WAKE_GPIO, // wake pin
   input wire logic I_WAKE_RTC, // real time clock wake
   input wire logic I_WAKE_WDT, // watchdog wake
   input wire logic I_WAKE_LOW_POWER_COMPARATOR, // comparator wake
   input wire logic I_VERIFY_DONE, // image check finished
   input wire logic I_VERIFY_OK, // image check passed
   output logic O_CPU_RUN, // processor executing
   output logic O_SYS_RST_B, // system reset, active low
   output logic O_SRAM_RET, // sram contents kept
   output logic O_VERIFY_REQ, // request image check
   output logic O_APP_START, // pulse: start first secure app
   output logic O_NS_LAUNCH // launch non-secure app
);
   import etd_pkg::*;
   // -----------------------------------------------------------------
   // decode helper
   // -----------------------------------------------------------------
   // word match on a register offset
   function automatic logic reg_hit(input logic [11:0] a,
                                    input logic [11:0] ofs);
      reg_hit = (a[11:2] == ofs[11:2]);
   endfunction
   // -----------------------------------------------------------------
   // ahb-lite address phase capture
   // -----------------------------------------------------------------
   logic wr_q; // write data phase pending
   logic [11:0] addr_q; // captured address
   logic [31:0] rdata_q; // read data flop
   logic [31:0] rdata_d; // read data mux
   wire addr_ph = I_HSEL & I_HTRANS[1] & I_HREADY; // transfer taken
   // capture the address phase; read data is ready for the data phase
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         wr_q <= 1'b0;
         addr_q <= 12'h000;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= addr_ph & I_HWRITE;
         addr_q <= addr_ph ? I_HADDR : addr_q;
         rdata_q <= (addr_ph & ~I_HWRITE) ? rdata_d : rdata_q;
      end
   end
   // zero-wait slave: ready and okay from reset onward
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end
   end
   assign O_HRDATA = rdata_q;
   // write strobes for the data phase
   wire wr_ctrl = wr_q & reg_hit(addr_q, ETD_CTRL_OFS);
   wire wr_stat = wr_q & reg_hit(addr_q, ETD_STAT_OFS);
   wire wr_pwr = wr_q & reg_hit(addr_q, ETD_PWR_OFS);
   wire wr_wken = wr_q & reg_hit(addr_q, ETD_WKEN_OFS);
   wire wr_bkp = wr_q & (addr_q[11:4] == ETD_BKP_OFS[11:4]);
   // -----------------------------------------------------------------
   // state and configuration registers
   // -----------------------------------------------------------------
   etd_state_t state_q; // sequencer state
   etd_state_t state_d; // next state
   logic [5:0] ctrl_q; // control bits
   logic [5:0] ctrl_d; // next control
   logic [3:0] wken_q; // hibernate wake enables
   logic [1:0] pmode_q; // last requested mode
   logic cold_q; // last wake went through cold boot
   logic flag_q; // sticky tamper event
   logic [31:0] cnt_q; // wait counter
   logic [31:0] bkp_q [ETD_BKP_NUM]; // retained words
   wire det_en = ctrl_q[CTRL_DET_EN];
   wire active = ctrl_q[CTRL_ACTIVE];
   wire invert = ctrl_q[CTRL_INVERT];
   wire sboot = ctrl_q[CTRL_SBOOT];
   wire init_done = ctrl_q[CTRL_INIT_DONE];
   // entering boot from any other state is a cold boot
   wire cold_entry = (state_d == ST_BOOT) & (state_q != ST_BOOT);
   // setup must finish before the launch bit can take
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = I_HWDATA[CTRL_W-1:0];
         ctrl_d[CTRL_NS_GO] = I_HWDATA[CTRL_NS_GO] & init_done;
      end
      if (cold_entry) begin
         // software must redo setup after every cold boot
         ctrl_d[CTRL_INIT_DONE] = 1'b0;
         ctrl_d[CTRL_NS_GO] = 1'b0;
      end
   end
   // control lives in the always-on domain; all but the setup and launch bits, cleared on a cold boot, survive low power
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl_q <= CTRL_RST;
         wken_q <= WKEN_RST;
         pmode_q <= PM_SLEEP;
      end else begin
         ctrl_q <= ctrl_d;
         wken_q <= wr_wken ? I_HWDATA[3:0] : wken_q;
         pmode_q <= wr_pwr ? I_HWDATA[1:0] : pmode_q;
      end
   end
   // backup words: only power-on reset clears them, never a cold boot
   genvar gi;
   generate
      for (gi = 0; gi < ETD_BKP_NUM; gi++) begin : g_bkp
         always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               bkp_q[gi] <= 32'h0000_0000;
            end else if (wr_bkp && addr_q[3:2] == 2'(gi)) begin
               bkp_q[gi] <= I_HWDATA;
            end
         end
      end
   endgenerate
   // -----------------------------------------------------------------
   // loop drive and compare
   // -----------------------------------------------------------------
   logic pat_bit; // pattern source
   logic drive_q; // value on the drive pin
   logic oe_q; // drive pin enabled
   logic [2:0] cfg_q; // config seen last cycle
   logic live_q; // mismatch seen
   etd_pattern_gen u_pat (
      .i_clk(I_SYS_CLK),
      .i_rst_b(I_RST_B),
      .i_run(det_en & active),
      .o_bit(pat_bit)
   );
   // passive drives the idle level, active drives the pattern
   wire drive_d = active ? pat_bit : invert;
   // compare only once drive and config have settled for a cycle
   wire cmp_ok = det_en & oe_q & (cfg_q == {det_en, active, invert});
   // expected is what stands on the pin now
   wire expect_v = active ? drive_q : invert;
   wire mismatch = cmp_ok & (I_TAMPER_IN != expect_v);
   // drive flops; oe low floats the pin when disarmed
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         drive_q <= 1'b0;
         oe_q <= 1'b0;
         cfg_q <= 3'h0;
         live_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
         oe_q <= det_en;
         cfg_q <= {det_en, active, invert};
         live_q <= mismatch;
      end
   end
   assign O_TAMPER_OUT = drive_q;
   assign O_TAMPER_OE = oe_q; // push-pull while enabled
   // sticky flag: a new event wins over a clear in the same cycle
   wire flag_clr = wr_stat & I_HWDATA[STAT_FLAG];
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= mismatch | (flag_q & ~flag_clr);
      end
   end
   assign O_TAMPER_EVT = flag_q;
   // -----------------------------------------------------------------
   // wake qualification
   // -----------------------------------------------------------------
   wire [3:0] wk_in = {I_WAKE_LOW_POWER_COMPARATOR, I_WAKE_WDT,
                       I_WAKE_RTC, I_WAKE_GPIO | mismatch};
   wire sleep_wake = I_IRQ_ANY | mismatch;
   wire deep_wake = |wk_in; // clocked peripherals
   wire hib_wake = |(wk_in & wken_q); // listed sources only
   wire pwr_go = wr_pwr & (state_q == ST_RUN);
   wire por_done = cnt_q >= 32'(P_POR_CYC - 1);
   wire boot_done = cnt_q >= 32'(P_BOOT_CYC - 1);
   wire res_done = cnt_q >= DS_RESUME_CYC - 32'd1;
   // -----------------------------------------------------------------
   // power and boot sequencer
   // -----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (pwr_go) begin
               case (I_HWDATA[1:0])
                  PM_SLEEP: state_d = ST_SLEEP;
                  PM_DSLEEP: state_d = ST_DSLEEP;
                  PM_DSOFF: state_d = ST_DSOFF;
                  default: state_d = ST_HIBER;
               endcase
            end
         end
         ST_SLEEP: state_d = sleep_wake ? ST_RUN : ST_SLEEP;
         ST_DSLEEP: state_d = deep_wake ? ST_RESUME : ST_DSLEEP;
         // resume without a reboot
         ST_RESUME: state_d = res_done ? ST_RUN : ST_RESUME;
         ST_DSOFF: state_d = deep_wake ? ST_BOOT : ST_DSOFF;
         ST_HIBER: state_d = hib_wake ? ST_POR : ST_HIBER;
         ST_POR: begin
            if (por_done) begin
               state_d = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (boot_done) begin
               state_d = sboot ? ST_VERIFY : ST_RUN;
            end
         end
         ST_VERIFY: begin
            if (I_VERIFY_DONE) begin
               state_d = I_VERIFY_OK ? ST_RUN : ST_HALT;
            end
         end
         ST_HALT: begin
            state_d = ST_HALT; // rejected image, only por leaves
         end
         default: begin
            state_d = ST_BOOT;
         end
      endcase
   end
   // app starts on boot exit, after a passed check when enabled
   wire app_d = ((state_q == ST_BOOT) & boot_done & ~sboot) |
                ((state_q == ST_VERIFY) & I_VERIFY_DONE & I_VERIFY_OK);
   // sram survives only the resume modes
   wire sram_d = (state_d == ST_RUN) | (state_d == ST_SLEEP) |
                 (state_d == ST_DSLEEP) | (state_d == ST_RESUME);
   // power-on reset itself starts a cold boot
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_q <= ST_BOOT;
         cnt_q <= 32'h0000_0000;
         cold_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q) ? 32'h0000_0000 : cnt_q + 32'd1;
         cold_q <= cold_entry ? 1'b1 : (wr_stat ? 1'b0 : cold_q);
      end
   end
   // outputs, each straight from a flop
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_CPU_RUN <= 1'b0;
         O_SYS_RST_B <= 1'b0;
         O_SRAM_RET <= 1'b0;
         O_VERIFY_REQ <= 1'b0;
         O_APP_START <= 1'b0;
         O_NS_LAUNCH <= 1'b0;
      end else begin
         O_CPU_RUN <= (state_d == ST_RUN);
         O_SYS_RST_B <= (state_d != ST_POR) & (state_d != ST_HIBER) &
                        (state_d != ST_DSOFF);
         O_SRAM_RET <= sram_d;
         O_VERIFY_REQ <= (state_d == ST_VERIFY);
         O_APP_START <= app_d;
         O_NS_LAUNCH <= ctrl_d[CTRL_NS_GO] & ctrl_d[CTRL_INIT_DONE];
      end
   end
   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   wire [31:0] stat_v = {19'h0, cold_q, state_q, live_q, flag_q};
   assign rdata_d =
      reg_hit(I_HADDR, ETD_CTRL_OFS) ? {26'h0, ctrl_q} :
      reg_hit(I_HADDR, ETD_STAT_OFS) ? stat_v :
      reg_hit(I_HADDR, ETD_PWR_OFS) ? {30'h0, pmode_q} :
      reg_hit(I_HADDR, ETD_WKEN_OFS) ? {28'h0, wken_q} :
      (I_HADDR[11:4] == ETD_BKP_OFS[11:4]) ? bkp_q[I_HADDR[3:2]] :
      32'h0000_0000;
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_mismatch_flags: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B) mismatch |=> flag_q)
      else $error("mismatch did not raise the flag");
   a_passive_rise: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (cmp_ok && !active && !invert && I_TAMPER_IN) |=> flag_q)
      else $error("high sense in low-idle mode missed");
   a_drive_idle: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (det_en && !active) ##1 (det_en && !active)
      |-> O_TAMPER_OE && O_TAMPER_OUT == $past(invert))
      else $error("idle level not driven while armed");
   a_float_off: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B) !det_en |=> !O_TAMPER_OE)
      else $error("drive left on while disarmed");
   a_active_cmp: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (cmp_ok && active && I_TAMPER_IN != O_TAMPER_OUT) |=> flag_q)
      else $error("pattern mismatch missed");
   a_flag_sticky: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B) (flag_q && !flag_clr) |=> flag_q)
      else $error("tamper flag dropped without a clear");
   a_sleep_wake: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_SLEEP && sleep_wake) |=> O_CPU_RUN)
      else $error("sleep wake took more than one cycle");
   a_resume_bound: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_RESUME) |-> cnt_q < DS_RESUME_CYC)
      else $error("deep sleep resume too slow");
   a_hib_sources: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_HIBER && !hib_wake) |=> state_q == ST_HIBER)
      else $error("hibernate left without a listed source");
   a_sram_lost: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_HIBER || state_q == ST_DSOFF) |-> !O_SRAM_RET)
      else $error("sram kept in an off mode");
   a_verify_fail: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_VERIFY && I_VERIFY_DONE && !I_VERIFY_OK)
      |=> state_q == ST_HALT && !O_APP_START)
      else $error("failed image was started");
   a_ns_gated: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B) O_NS_LAUNCH |-> $past(init_done))
      else $error("non-secure launch before setup");
   a_off_reset: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RST_B)
      (state_q == ST_HIBER || state_q == ST_DSOFF || state_q == ST_POR)
      |-> !O_SYS_RST_B)
      else $error("system reset released in an off mode");
endmodule
`default_nettype wire

// ---- verification/etd_loop_model.sv ----
// loop model: switch or mesh between drive and sense pins
`timescale 1ns/10ps
`default_nettype none
module etd_loop_model (
   input wire logic i_drive, // driven loop value
   input wire logic i_drive_oe, // drive enable
   input wire logic i_open, // loop broken by tamper
   input wire logic i_pull_high, // pull resistor level
   output logic o_sense // value seen at sense pin
);
   // open or undriven loop falls to the pull level
   assign o_sense = (i_drive_oe && !i_open) ?
      i_drive : i_pull_high;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench: loop detection, power modes and register checks
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import etd_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic irq = 1'b0, open = 1'b0, pull_hi = 1'b1;
   logic vdone = 1'b0, vok = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = 32'h0, hrdata, rd, bk;
   logic [3:0] wk = 4'h0;
   logic hready, hresp, t_out, t_oe, evt, sense, cpu, srst_b, sret;
   logic vreq, app, ns;
   int error_cnt = 0, checked = 0, n, starts = 0;
   always #4 clk = ~clk;
   // count first-app starts
   always @(posedge clk) if (app === 1'b1) starts <= starts + 1;
   etd_top #(.P_POR_CYC(20), .P_BOOT_CYC(30)) dut (.I_SYS_CLK(clk),
      .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
      .O_HRESP(hresp), .I_TAMPER_IN(sense), .O_TAMPER_OUT(t_out),
      .O_TAMPER_OE(t_oe), .O_TAMPER_EVT(evt), .I_IRQ_ANY(irq),
      .I_WAKE_GPIO(wk[0]), .I_WAKE_RTC(wk[1]), .I_WAKE_WDT(wk[2]),
      .I_WAKE_LOW_POWER_COMPARATOR(wk[3]), .I_VERIFY_DONE(vdone),
      .I_VERIFY_OK(vok), .O_CPU_RUN(cpu), .O_SYS_RST_B(srst_b),
      .O_SRAM_RET(sret), .O_VERIFY_REQ(vreq), .O_APP_START(app),
      .O_NS_LAUNCH(ns));
   etd_loop_model model (.i_drive(t_out), .i_drive_oe(t_oe), .i_open(open),
      .i_pull_high(pull_hi), .o_sense(sense));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single ahb transfer, waits on hready in both phases
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task stop_test;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: whole run is well under 5000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test;
   end
   initial begin
      void'($urandom(22));
      cyc(3);
      @(posedge clk) rst_b <= 1'b1;
      cyc(40);
      chk({hready, hresp, cpu, vreq}, 4'ha);
      chk(starts, 1);
      ahb(0, ETD_WKEN_OFS, 0);
      chk(rd, 32'hf);
      ahb(0, 12'h0f0, 0);
      chk(rd, 0);
      $display("register test done");
      for (int p = 0; p < 2; p++) begin
         @(posedge clk) pull_hi <= (p == 0);
         ahb(1, ETD_CTRL_OFS, p ? 32'h5 : 32'h1);
         cyc($urandom_range(12, 3));
         chk({t_oe, t_out, evt}, {1'b1, p[0], 1'b0});
         @(posedge clk) open <= 1'b1;
         cyc(3);
         chk(evt, 1);
         @(posedge clk) open <= 1'b0;
         cyc(5);
         chk(evt, 1);
         ahb(1, ETD_STAT_OFS, 1);
         cyc(2);
         chk(evt, 0);
      end
      $display("passive test done");
      @(posedge clk) pull_hi <= 1'b0;
      ahb(1, ETD_CTRL_OFS, 32'h3);
      n = 0;
      repeat (40) begin
         @(posedge clk) #1;
         n += int'(t_out === 1'b1);
      end
      chk(n > 0 && n < 40 && evt === 1'b0, 1);
      @(posedge clk) open <= 1'b1;
      cyc(20);
      chk(evt, 1);
      ahb(1, ETD_CTRL_OFS, 0);
      @(posedge clk) open <= 1'b0;
      ahb(1, ETD_STAT_OFS, 1);
      cyc(2);
      chk({t_oe, evt}, 0);
      $display("active test done");
      ahb(1, ETD_PWR_OFS, PM_SLEEP);
      cyc(3);
      chk(cpu, 0);
      @(posedge clk) irq <= 1'b1;
      cyc(1);
      chk(cpu, 1);
      @(posedge clk) irq <= 1'b0;
      ahb(1, ETD_PWR_OFS, PM_DSLEEP);
      @(posedge clk) wk <= 4'h2;
      n = 0;
      while (cpu !== 1'b1 && n < 3000) begin
         @(posedge clk) #1;
         n++;
      end
      chk(n <= DS_RESUME_NS * CLK_MHZ / 1000 && sret === 1'b1, 1);
      @(posedge clk) wk <= 4'h0;
      bk = $urandom;
      ahb(1, ETD_BKP_OFS + 12'h004, bk);
      ahb(1, ETD_WKEN_OFS, 32'h2);
      ahb(1, ETD_PWR_OFS, PM_HIBER);
      @(posedge clk) wk <= 4'hd;
      cyc(100);
      chk({cpu, sret}, 0);
      @(posedge clk) wk <= 4'h2;
      cyc(3);
      chk(srst_b, 0);
      @(posedge clk) wk <= 4'h0;
      cyc(60);
      chk({cpu, starts[1:0]}, 3'h6);
      ahb(0, ETD_BKP_OFS + 12'h004, 0);
      chk(rd, bk);
      ahb(0, ETD_STAT_OFS, 0);
      chk(rd[STAT_COLD], 1);
      $display("power test done");
      ahb(1, ETD_CTRL_OFS, 32'h20);
      cyc(2);
      chk(ns, 0);
      ahb(1, ETD_CTRL_OFS, 32'h10);
      ahb(1, ETD_CTRL_OFS, 32'h30);
      cyc(2);
      chk(ns, 1);
      $display("launch test done");
      // secure boot on: one passing and one failing image check
      ahb(1, ETD_CTRL_OFS, 32'h8);
      for (int f = 0; f < 2; f++) begin
         ahb(1, ETD_PWR_OFS, PM_DSOFF);
         cyc(2);
         chk({srst_b, sret}, 0);
         @(posedge clk) wk <= 4'h1 << $urandom_range(3, 0);
         @(posedge clk) wk <= 4'h0;
         cyc(40);
         chk({vreq, cpu, starts[1:0]}, {2'h2, 2'(2 + f)});
         @(posedge clk) {vdone, vok} <= {1'b1, f == 0};
         @(posedge clk) vdone <= 1'b0;
         cyc(2);
         chk({cpu, vreq, starts[1:0]}, {f == 0, 1'b0, 2'h3});
      end
      ahb(0, ETD_STAT_OFS, 0);
      chk(rd[STAT_ST_LSB +: 10], ST_HALT);
      // only a power-on reset leaves a rejected image
      @(posedge clk) rst_b <= 1'b0;
      cyc(2);
      chk({srst_b, cpu, hready}, 3'h1);
      @(posedge clk) rst_b <= 1'b1;
      cyc(40);
      chk({cpu, vreq, starts[1:0]}, 4'h8);
      ahb(0, ETD_BKP_OFS + 12'h004, 0);
      chk(rd, 0);
      $display("verify and reset test done");
      stop_test;
   end
endmodule
`default_nettype wire
